// File: hw/timer_compare_pulse_pwm.sv
// output compare, single-pulse and pwm logic of a 16-bit timer with an apb slave
// assumes the free-running counter, prescaler and overflow logic sit outside;
// the counter loads its reload value on counter_reload
// Functional notes
// - two compare values, compared every timer clock
// - reset loads 8000h, compare pins low
// - normal match sets flag, copies level
// - interrupt needs enable and clear cpu mask
// - flag cleared by flags read, low access
// - high byte write inhibits channel compares
// - low byte write re-enables, completes clearing
// - pin disabled: flag still set, pin free
// - div2 matches equal, others equal plus one
// - force bit copies level, no flag
// - force bits ignored in special modes
// - single-pulse mode uses capture and compare
// - capture edge reloads counter, starts pulse
// - first compare match ends the pulse
// - single-pulse: no first flag, second pin idle
// - both selects set means pwm only
// - pwm second match reloads counter
// - pwm matches drive first and second levels
// - pwm sets no compare flags
// - pwm second match sets capture flag
// - pwm disconnects the first capture pin
// - equal levels give a constant pin
// - clock select 11 picks external clock
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "timer_compare_params.svh"
module timer_compare_pulse_pwm
	import timer_compare_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] counter_value,
	input wire logic first_capture_pin,
	input wire logic cpu_irq_mask,
	output logic counter_reload,
	output logic [1:0] timer_clock_select,
	output logic [1:0] compare_output_pin,
	output logic [1:0] compare_output_enable,
	output logic timer_irq
);
	logic [7:0] timer_control_first;
	logic [7:0] timer_control_second;
	logic compare_match_flag_1;
	logic compare_match_flag_2;
	logic first_capture_flag;
	logic arm_cmp1;
	logic arm_cmp2;
	logic arm_cap1;
	logic [15:0] first_capture_value;
	logic [1:0] pin_latch;
	logic cap_edge;

	compare_chan_if ch1 ();
	compare_chan_if ch2 ();

	// apb decode
	wire access = psel && penable && pready;
	wire wr = access && pwrite;
	wire rd = access && !pwrite;
	wire [7:0] wbyte = pwdata[7:0];
	wire sel_ctl1 = (paddr == `OFS_CONTROL_FIRST);
	wire sel_ctl2 = (paddr == `OFS_CONTROL_SECOND);
	wire sel_flags = (paddr == `OFS_FLAGS);
	wire sel_c1h = (paddr == `OFS_CMP1_HIGH);
	wire sel_c1l = (paddr == `OFS_CMP1_LOW);
	wire sel_c2h = (paddr == `OFS_CMP2_HIGH);
	wire sel_c2l = (paddr == `OFS_CMP2_LOW);
	wire sel_cap_h = (paddr == `OFS_CAP1_HIGH);
	wire sel_cap_l = (paddr == `OFS_CAP1_LOW);
	wire mapped = sel_ctl1 || sel_ctl2 || sel_flags || sel_c1h || sel_c1l || sel_c2h
		|| sel_c2l || sel_cap_h || sel_cap_l;

	// control fields
	wire ic_ie = timer_control_first[`BIT_CAPTURE_IRQ_ENABLE];
	wire oc_ie = timer_control_first[`BIT_COMPARE_IRQ_ENABLE];
	wire force_1 = timer_control_first[`BIT_FORCE_FIRST];
	wire force_2 = timer_control_first[`BIT_FORCE_SECOND];
	wire first_output_level = timer_control_first[`BIT_FIRST_LEVEL];
	wire second_output_level = timer_control_first[`BIT_SECOND_LEVEL];
	wire capture_edge_select = timer_control_first[`BIT_CAPTURE_EDGE];
	wire [1:0] pin_en = {timer_control_second[`BIT_PIN_ENABLE_SECOND],
		timer_control_second[`BIT_PIN_ENABLE_FIRST]};
	wire single_sel = timer_control_second[`BIT_SINGLE_PULSE];
	wire pwm_sel = timer_control_second[`BIT_PWM];
	wire [1:0] clk_sel = timer_control_second[`BIT_CLOCK_SEL_HI:`BIT_CLOCK_SEL_LO];

	// pwm wins when both selects are set
	wire timer_mode_t mode = pwm_sel ? MODE_PWM : (single_sel ? MODE_SINGLE : MODE_COMPARE);
	wire is_pwm = (mode == MODE_PWM);
	wire is_single = (mode == MODE_SINGLE);
	wire is_normal = (mode == MODE_COMPARE);
	wire plus_one = (timer_clock_t'(clk_sel) != CLK_DIV2);

	// channel byte writes
	assign ch1.wr_high = wr && sel_c1h;
	assign ch1.wr_low = wr && sel_c1l;
	assign ch1.wdata = wbyte;
	assign ch2.wr_high = wr && sel_c2h;
	assign ch2.wr_low = wr && sel_c2l;
	assign ch2.wdata = wbyte;

	compare_channel u_cmp1 (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.counter_value(counter_value),
		.plus_one(plus_one),
		.bus(ch1.chan)
	);

	compare_channel u_cmp2 (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.counter_value(counter_value),
		.plus_one(plus_one),
		.bus(ch2.chan)
	);

	pin_edge_detect u_cap1 (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.pin(first_capture_pin),
		.rising(capture_edge_select),
		.edge_seen(cap_edge)
	);

	wire m1 = ch1.match;
	wire m2 = ch2.match;
	wire cap_used = cap_edge && !is_pwm;
	wire pulse_start = cap_used && is_single;
	wire pwm_period = m2 && is_pwm;

	// flag set terms
	wire set_cmp1 = m1 && is_normal;
	wire set_cmp2 = m2 && !is_pwm;
	wire set_cap1 = cap_used || pwm_period;

	// clear terms: armed by a flags read, fired by the matching low byte access
	wire flags_read = rd && sel_flags;
	wire clr_cmp1 = access && sel_c1l && arm_cmp1;
	wire clr_cmp2 = access && sel_c2l && arm_cmp2;
	wire clr_cap1 = access && sel_cap_l && arm_cap1;

	// first pin: mode events take over from force in special modes
	wire force_ok = is_normal;
	logic next_pin_1;
	logic next_pin_2;
	always_comb begin
		next_pin_1 = pin_latch[0];
		unique case (mode)
			MODE_PWM: begin
				if (m2) begin
					next_pin_1 = second_output_level;
				end else if (m1) begin
					next_pin_1 = first_output_level;
				end
			end
			MODE_SINGLE: begin
				if (pulse_start) begin
					next_pin_1 = second_output_level;
				end else if (m1) begin
					next_pin_1 = first_output_level;
				end
			end
			MODE_COMPARE: begin
				if ((force_1 && force_ok) || m1) begin
					next_pin_1 = first_output_level;
				end
			end
			default: begin
				next_pin_1 = pin_latch[0];
			end
		endcase
	end

	always_comb begin
		next_pin_2 = pin_latch[1];
		if (force_ok && (force_2 || m2)) begin
			next_pin_2 = second_output_level;
		end
	end

	wire [7:0] flags_byte = {5'b00000, first_capture_flag, compare_match_flag_2,
		compare_match_flag_1};
	wire [7:0] read_byte = sel_ctl1 ? timer_control_first :
		sel_ctl2 ? timer_control_second :
		sel_flags ? flags_byte :
		sel_c1h ? ch1.value[15:8] :
		sel_c1l ? ch1.value[7:0] :
		sel_c2h ? ch2.value[15:8] :
		sel_c2l ? ch2.value[7:0] :
		sel_cap_h ? first_capture_value[15:8] :
		sel_cap_l ? first_capture_value[7:0] : 8'h00;

	wire irq_req = ((compare_match_flag_1 || compare_match_flag_2) && oc_ie
		|| first_capture_flag && ic_ie) && !cpu_irq_mask;

	// apb handshake: one wait state, answer registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (ce) begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !mapped;
			prdata <= (psel && penable && !pready && !pwrite) ? {24'h000000, read_byte}
				: 32'h00000000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_control_first <= `CONTROL_RESET;
			timer_control_second <= `CONTROL_RESET;
		end else if (ce) begin
			if (wr && sel_ctl1) begin
				timer_control_first <= wbyte;
			end
			if (wr && sel_ctl2) begin
				timer_control_second <= wbyte;
			end
		end
	end

	// flags: set wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_match_flag_1 <= 1'b0;
			compare_match_flag_2 <= 1'b0;
			first_capture_flag <= 1'b0;
		end else if (ce) begin
			compare_match_flag_1 <= set_cmp1 || (compare_match_flag_1 && !clr_cmp1);
			compare_match_flag_2 <= set_cmp2 || (compare_match_flag_2 && !clr_cmp2);
			first_capture_flag <= set_cap1 || (first_capture_flag && !clr_cap1);
		end
	end

	// arming survives until the low byte access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arm_cmp1 <= 1'b0;
			arm_cmp2 <= 1'b0;
			arm_cap1 <= 1'b0;
		end else if (ce) begin
			arm_cmp1 <= (flags_read && compare_match_flag_1) || (arm_cmp1 && !clr_cmp1);
			arm_cmp2 <= (flags_read && compare_match_flag_2) || (arm_cmp2 && !clr_cmp2);
			arm_cap1 <= (flags_read && first_capture_flag) || (arm_cap1 && !clr_cap1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_capture_value <= 16'h0000;
		end else if (ce && cap_used) begin
			first_capture_value <= is_single ? `CAPTURE_PULSE_VALUE : counter_value;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_latch <= 2'b00;
			compare_output_pin <= 2'b00;
			compare_output_enable <= 2'b00;
			counter_reload <= 1'b0;
			timer_clock_select <= 2'b00;
			timer_irq <= 1'b0;
		end else if (ce) begin
			pin_latch <= {next_pin_2, next_pin_1};
			compare_output_pin <= {next_pin_2, next_pin_1} & pin_en;
			compare_output_enable <= pin_en;
			counter_reload <= pulse_start || pwm_period;
			timer_clock_select <= clk_sel;
			timer_irq <= irq_req;
		end
	end
endmodule : timer_compare_pulse_pwm

// File: common/timer_compare_params.svh
// register offsets, field positions, reset values and timing of the compare/pulse/pwm block
// assumes a 32-bit apb with byte addresses in the low eight bits
`ifndef TIMER_COMPARE_PARAMS_SVH
`define TIMER_COMPARE_PARAMS_SVH

`define OFS_CONTROL_FIRST 8'h00
`define OFS_CONTROL_SECOND 8'h04
`define OFS_FLAGS 8'h08
`define OFS_CMP1_HIGH 8'h0C
`define OFS_CMP1_LOW 8'h10
`define OFS_CMP2_HIGH 8'h14
`define OFS_CMP2_LOW 8'h18
`define OFS_CAP1_HIGH 8'h1C
`define OFS_CAP1_LOW 8'h20

// timer_control_first fields
`define BIT_CAPTURE_IRQ_ENABLE 7
`define BIT_COMPARE_IRQ_ENABLE 6
`define BIT_FORCE_SECOND 4
`define BIT_FORCE_FIRST 3
`define BIT_SECOND_LEVEL 2
`define BIT_CAPTURE_EDGE 1
`define BIT_FIRST_LEVEL 0

// timer_control_second fields
`define BIT_PIN_ENABLE_FIRST 7
`define BIT_PIN_ENABLE_SECOND 6
`define BIT_SINGLE_PULSE 5
`define BIT_PWM 4
`define BIT_CLOCK_SEL_HI 3
`define BIT_CLOCK_SEL_LO 2

// timer_flags_register fields
`define BIT_FLAG_CMP1 0
`define BIT_FLAG_CMP2 1
`define BIT_FLAG_CAP1 2

`define COMPARE_RESET 16'h8000
`define COUNTER_RELOAD 16'hFFFC
`define CAPTURE_PULSE_VALUE 16'hFFFD
`define CONTROL_RESET 8'h00

`define PCLK_PERIOD_NS 8
`define APB_WAIT_CYCLES 1

`endif

// File: common/timer_compare_pkg.sv
// types shared by the compare/pulse/pwm block
// assumes nothing beyond the params header
package timer_compare_pkg;
	typedef enum logic [1:0] {
		MODE_COMPARE = 2'b00,
		MODE_SINGLE = 2'b01,
		MODE_PWM = 2'b10
	} timer_mode_t;

	typedef enum logic [1:0] {
		CLK_DIV2 = 2'b00,
		CLK_DIV4 = 2'b01,
		CLK_DIV8 = 2'b10,
		CLK_EXTERNAL = 2'b11
	} timer_clock_t;
endpackage : timer_compare_pkg

// File: common/compare_chan_if.sv
// byte writes into one compare channel and its match event back
// assumes the channel and its controller share pclk
`timescale 1ns/1ps
interface compare_chan_if;
	logic wr_high;
	logic wr_low;
	logic [7:0] wdata;
	logic [15:0] value;
	logic match;

	modport ctrl (output wr_high, output wr_low, output wdata, input value, input match);
	modport chan (input wr_high, input wr_low, input wdata, output value, output match);
endinterface : compare_chan_if

// File: hw/compare_channel.sv
// one 16-bit compare value with high-byte inhibit and match event
// assumes counter_value changes only on timer ticks
`timescale 1ns/1ps
`include "timer_compare_params.svh"
module compare_channel
	import timer_compare_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [15:0] counter_value,
	input wire logic plus_one,
	compare_chan_if.chan bus
);
	logic [15:0] value;
	logic inhibit;
	logic eq_prev;
	logic match;
	wire [15:0] target = plus_one ? 16'(value + 16'h0001) : value;
	wire eq = (counter_value == target) && !inhibit;

	assign bus.value = value;
	assign bus.match = match;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value <= `COMPARE_RESET;
			inhibit <= 1'b0;
			eq_prev <= 1'b0;
			match <= 1'b0;
		end else if (ce) begin
			if (bus.wr_high) begin
				value[15:8] <= bus.wdata;
				inhibit <= 1'b1;
			end else if (bus.wr_low) begin
				value[7:0] <= bus.wdata;
				inhibit <= 1'b0;
			end
			eq_prev <= eq;
			match <= eq && !eq_prev;
		end
	end
endmodule : compare_channel

// File: hw/pin_edge_detect.sv
// selected-edge detector for a synchronous pin
// assumes the pin is already synchronous to pclk
`timescale 1ns/1ps
module pin_edge_detect (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic pin,
	input wire logic rising,
	output logic edge_seen
);
	logic prev;
	logic primed;

	// first cycle after reset only learns the pin level, so no false edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev <= 1'b1;
			primed <= 1'b0;
			edge_seen <= 1'b0;
		end else if (ce) begin
			prev <= pin;
			primed <= 1'b1;
			edge_seen <= primed && (rising ? (pin && !prev) : (!pin && prev));
		end
	end
endmodule : pin_edge_detect

// File: dv/timer_compare_pulse_pwm_asserts.sv
// port checker for the compare, single-pulse and pwm block
// assumes one pclk domain and presetn asynchronous, active low
`timescale 1ns/1ps
module timer_compare_pulse_pwm_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cpu_irq_mask,
	input wire logic counter_reload,
	input wire logic [1:0] timer_clock_select,
	input wire logic [1:0] compare_output_pin,
	input wire logic [1:0] compare_output_enable,
	input wire logic timer_irq
);
	wire logic wr_done = psel && penable && pready && pwrite;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_wait; psel && penable && !$past(penable) |-> !pready ##1 pready; endproperty
	a_wait: assert property (p_wait) else $error("apb answer not after one wait");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("pready held too long");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("pslverr without pready");
	property p_rst;
		disable iff (1'b0) !presetn && !$past(presetn) |-> compare_output_pin == 2'b00;
	endproperty
	a_rst: assert property (p_rst) else $error("pin not low in reset");
	property p_gate; !compare_output_enable[0] |-> !compare_output_pin[0]; endproperty
	a_gate: assert property (p_gate) else $error("disabled pin driven");
	property p_reload; counter_reload |=> !counter_reload; endproperty
	a_reload: assert property (p_reload) else $error("reload not one cycle");
	property p_mask; cpu_irq_mask && $past(cpu_irq_mask) |-> !timer_irq; endproperty
	a_mask: assert property (p_mask) else $error("irq while masked");
	property p_clksel; $changed(timer_clock_select) |-> $past(wr_done, 2); endproperty
	a_clksel: assert property (p_clksel) else $error("clock select moved alone");
	c_reload: cover property (counter_reload);
	c_err: cover property (pslverr);
	c_irq: cover property (timer_irq);
endmodule : timer_compare_pulse_pwm_asserts

bind timer_compare_pulse_pwm timer_compare_pulse_pwm_asserts u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pready(pready), .pslverr(pslverr), .cpu_irq_mask(cpu_irq_mask),
	.counter_reload(counter_reload), .timer_clock_select(timer_clock_select),
	.compare_output_pin(compare_output_pin), .compare_output_enable(compare_output_enable),
	.timer_irq(timer_irq)
);

// File: dv/timer_far_side.sv
// far side: free-running counter and first capture pin
// assumes one count per pclk and a reload pulse from the block
`timescale 1ns/1ps
module timer_far_side (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic counter_reload,
	input wire logic cap_level,
	output logic [15:0] counter_value,
	output logic first_capture_pin
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) counter_value <= 16'hFFFC;
		else if (counter_reload) counter_value <= 16'hFFFC;
		else counter_value <= counter_value + 16'h0001;
	end
	assign first_capture_pin = cap_level;
endmodule : timer_far_side

// File: dv/tb_timer_compare_pulse_pwm.sv
// self-checking bench for the compare, single-pulse and pwm block
// assumes the far-side model makes the counter and the capture pin
`timescale 1ns/1ps
module tb_timer_compare_pulse_pwm;
	logic pclk, presetn, ce, psel, penable, pwrite, cap, mask, e, cap_pin;
	logic pready, pslverr, reload, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [15:0] cv, t;
	logic [1:0] csel, pin, oe;
	int fail_count = 0;
	int checked = 0;
	typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] x; logic e;} row_t;
	row_t rows [8] = '{'{1'b0, 8'h0C, 8'h00, 8'h80, 1'b0}, '{1'b0, 8'h10, 8'h00, 8'h00, 1'b0},
		'{1'b0, 8'h14, 8'h00, 8'h80, 1'b0}, '{1'b0, 8'h18, 8'h00, 8'h00, 1'b0},
		'{1'b1, 8'h0C, 8'h12, 8'h00, 1'b0}, '{1'b0, 8'h0C, 8'h00, 8'h12, 1'b0},
		'{1'b0, 8'h24, 8'h00, 8'h00, 1'b1}, '{1'b1, 8'h28, 8'h55, 8'h00, 1'b1}};
	timer_compare_pulse_pwm DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .counter_value(cv), .first_capture_pin(cap_pin),
		.cpu_irq_mask(mask), .counter_reload(reload), .timer_clock_select(csel),
		.compare_output_pin(pin), .compare_output_enable(oe), .timer_irq(irq));
	timer_far_side far (.pclk(pclk), .presetn(presetn), .counter_reload(reload),
		.cap_level(cap), .counter_value(cv), .first_capture_pin(cap_pin));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wrap_up();
		if (fail_count == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) chk(32'h0, 32'h1);
		if (n >= 16) wrap_up();
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rdc(input logic [7:0] a, input logic [7:0] x);
		apb(1'b0, a, 8'h00);
		chk(r, {24'h000000, x});
	endtask : rdc
	task automatic wv(input logic [7:0] a, input logic [15:0] v);
		apb(1'b1, a, v[15:8]);
		apb(1'b1, a + 8'h04, v[7:0]);
	endtask : wv
	task automatic until_cnt(input logic [15:0] v);
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (cv !== v && n < 400);
		if (n >= 400) chk(32'h0, 32'h2);
		if (n >= 400) wrap_up();
	endtask : until_cnt
	initial begin
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		mask = 1'b0;
		cap = 1'b1;
		tick(12);
		presetn <= 1'b1;
		tick(1);
		chk(32'(pin), 32'h0);
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			chk(32'(e), 32'(rows[i].e));
			if (!rows[i].w) chk(r, {24'h000000, rows[i].x});
		end
		// normal match, divide by two
		apb(1'b1, 8'h04, 8'h80);
		apb(1'b1, 8'h00, 8'h41);
		t = cv + 16'h0040;
		wv(8'h0C, t);
		until_cnt(t);
		tick(1);
		chk(32'(pin), 32'h0);
		tick(1);
		chk(32'(pin), 32'h1);
		chk(32'(oe), 32'h1);
		tick(1);
		chk(32'(irq), 32'h1);
		rdc(8'h08, 8'h01);
		rdc(8'h10, t[7:0]);
		rdc(8'h08, 8'h00);
		chk(32'(irq), 32'h0);
		// masked, divide by four matches one later
		mask <= 1'b1;
		apb(1'b1, 8'h04, 8'h84);
		apb(1'b1, 8'h00, 8'h40);
		t = cv + 16'h0040;
		wv(8'h0C, t);
		until_cnt(t);
		tick(2);
		chk(32'(pin), 32'h1);
		tick(1);
		chk(32'(pin), 32'h0);
		chk(32'(irq), 32'h0);
		apb(1'b1, 8'h04, 8'h8C);
		tick(1);
		chk(32'(csel), 32'h3);
		rdc(8'h08, 8'h01);
		apb(1'b0, 8'h10, 8'h00);
		// forced level
		apb(1'b1, 8'h00, 8'h09);
		tick(2);
		chk(32'(pin), 32'h1);
		apb(1'b1, 8'h00, 8'h08);
		tick(2);
		chk(32'(pin), 32'h0);
		rdc(8'h08, 8'h00);
		// force off with level 1: pin keeps the forced 0
		apb(1'b1, 8'h00, 8'h01);
		tick(2);
		chk(32'(pin), 32'h0);
		// high byte write inhibits channel two
		apb(1'b1, 8'h04, 8'h40);
		apb(1'b1, 8'h00, 8'h04);
		t = cv + 16'h0040;
		wv(8'h14, t);
		apb(1'b1, 8'h14, t[15:8]);
		until_cnt(t);
		tick(3);
		chk(32'(pin), 32'h0);
		chk(32'(oe), 32'h2);
		t = cv + 16'h0020;
		wv(8'h14, t);
		until_cnt(t);
		tick(2);
		chk(32'(pin), 32'h2);
		rdc(8'h08, 8'h02);
		apb(1'b0, 8'h18, 8'h00);
		// single pulse on a falling capture edge
		apb(1'b1, 8'h04, 8'hA0);
		wv(8'h0C, 16'h0008);
		// force with level 1 would raise the pin if honoured
		apb(1'b1, 8'h00, 8'h0D);
		tick(3);
		chk(32'(pin), 32'h0);
		apb(1'b1, 8'h00, 8'h0C);
		cap <= 1'b0;
		tick(3);
		chk(32'(reload), 32'h1);
		chk(32'(pin), 32'h1);
		until_cnt(16'h0008);
		tick(2);
		chk(32'(pin), 32'h0);
		cap <= 1'b1;
		rdc(8'h08, 8'h04);
		rdc(8'h1C, 8'hFF);
		rdc(8'h20, 8'hFD);
		// pwm with both selects set
		apb(1'b1, 8'h04, 8'hB0);
		apb(1'b1, 8'h00, 8'h04);
		wv(8'h0C, 16'h0080);
		wv(8'h14, 16'h00C0);
		until_cnt(16'h00C0);
		tick(2);
		chk(32'(reload), 32'h1);
		chk(32'(pin), 32'h1);
		until_cnt(16'h0080);
		tick(2);
		chk(32'(pin), 32'h0);
		rdc(8'h08, 8'h04);
		// capture pin edge in pwm: no reload, no capture load
		cap <= 1'b0;
		tick(3);
		chk(32'(reload), 32'h0);
		rdc(8'h20, 8'hFD);
		// equal levels: pin stays high through the first match
		apb(1'b1, 8'h00, 8'h05);
		until_cnt(16'h0080);
		tick(2);
		chk(32'(pin), 32'h1);
		presetn <= 1'b0;
		tick(2);
		presetn <= 1'b1;
		tick(1);
		rdc(8'h14, 8'h80);
		rdc(8'h08, 8'h00);
		wrap_up();
	end
endmodule : tb_timer_compare_pulse_pwm
